// *** logic/dog_based_homing_sequencer.sv ***
// Homing sequencer: dog rear-end, counted front-end and dog cradle.
// Assumes the host holds config stable while homing runs; pins are async.
`timescale 1ns/10ps
`default_nettype none
module dog_based_homing_sequencer
  import homing_pkg::*;
#(
  parameter int unsigned DOG_TIMEOUT = DOG_TIMEOUT_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic dogPin,
  input wire logic zPhasePin,
  input wire logic posPulse,
  input wire logic auto_manual_select,
  input wire logic [7:0] pointSel,
  input wire logic pos_speed_source_select,
  input wire logic twoStations,
  input wire logic homeStart,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic [SPD_W-1:0] speedCmd,
  output logic speedDir,
  output logic [SPD_W-1:0] rampTime,
  output logic homing_complete_flag,
  output logic homingBusy,
  output logic homingAbort,
  output logic irq
);
  localparam int TO_W = $clog2(DOG_TIMEOUT + 1);
  // Config fields held in software registers
  logic [3:0] homing_method_cfg_q;
  logic homing_direction_cfg_q;
  logic dog_polarity_cfg_q;
  logic [SPD_W-1:0] homing_speed_cfg_q;
  logic [SPD_W-1:0] creep_speed_cfg_q;
  logic [POS_W-1:0] home_shift_distance_cfg_q;
  logic [POS_W-1:0] home_position_data_cfg_q;
  logic [POS_W-1:0] after_dog_distance_cfg_q;
  logic [SPD_W-1:0] point1Accel_q;
  logic [2:0] irqStat_q;
  logic [2:0] irqMask_q;
  logic [POS_W-1:0] position_q;
  home_state_type state_q;
  logic [POS_W-1:0] distLeft_q;
  logic [TO_W-1:0] timeout_q;
  logic dogSeen_q;
  logic dogPrev_q;
  logic zPrev_q;
  logic pulsePrev_q;
  logic [2:0] syncPins;
  logic dogActive;
  logic zEdge;
  logic moveTick;
  logic manualMode;
  logic startOk;
  logic evDone;
  logic evAbort;
  logic evDog;
  logic [POS_W-1:0] totalDist;

  pin_sync #(
    .WIDTH(3)
  ) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .asyncIn({posPulse, zPhasePin, dogPin}),
    .syncOut(syncPins)
  );

  assign dogActive = syncPins[0] ^ dog_polarity_cfg_q;
  assign zEdge = syncPins[1] & ~zPrev_q;
  assign moveTick = syncPins[2] & ~pulsePrev_q;
  // Host must select manual mode with all point bits low
  assign manualMode = auto_manual_select & (pointSel == 8'h00);
  assign startOk = manualMode & (~twoStations | pos_speed_source_select);
  // Shift and after-dog distances stay separate settings
  assign totalDist = after_dog_distance_cfg_q + home_shift_distance_cfg_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dogPrev_q <= 1'b0;
      zPrev_q <= 1'b0;
      pulsePrev_q <= 1'b0;
    end else begin
      dogPrev_q <= dogActive;
      zPrev_q <= syncPins[1];
      pulsePrev_q <= syncPins[2];
    end
  end

  // Sequencer; count-type home shifts with speed since decel starts at edge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= HS_IDLE;
      distLeft_q <= POS_RESET;
      timeout_q <= '0;
      dogSeen_q <= 1'b0;
    end else begin
      case (state_q)
        HS_IDLE, HS_DONE, HS_ABORT: begin
          if (homeStart && startOk) begin
            if (homing_method_cfg_q == METHOD_REAR ||
                homing_method_cfg_q == METHOD_FRONT ||
                homing_method_cfg_q == METHOD_CRADLE) begin
              state_q <= HS_FAST;
              timeout_q <= TO_W'(DOG_TIMEOUT);
              dogSeen_q <= 1'b0;
            end else begin
              state_q <= HS_ABORT;
            end
          end
        end
        HS_FAST: begin
          if (dogActive && !dogPrev_q) begin
            dogSeen_q <= 1'b1;
            timeout_q <= TO_W'(DOG_TIMEOUT);
            if (homing_method_cfg_q == METHOD_FRONT) begin
              state_q <= HS_COUNT;
              distLeft_q <= totalDist;
            end else begin
              state_q <= HS_CREEP;
            end
          end else if (timeout_q == '0) begin
            state_q <= HS_ABORT;
          end else begin
            timeout_q <= timeout_q - 1'b1;
          end
        end
        HS_CREEP: begin
          // Rear-end waits for dog release; Z-phase ignored there
          if (homing_method_cfg_q == METHOD_CRADLE && zEdge) begin
            state_q <= HS_COUNT;
            distLeft_q <= home_shift_distance_cfg_q;
          end else if (homing_method_cfg_q == METHOD_REAR &&
                       !dogActive && dogPrev_q) begin
            state_q <= HS_COUNT;
            distLeft_q <= totalDist;
          end else if (timeout_q == '0) begin
            state_q <= HS_ABORT;
          end else begin
            timeout_q <= timeout_q - 1'b1;
          end
        end
        HS_COUNT: begin
          if (distLeft_q == POS_RESET) begin
            state_q <= HS_DONE;
          end else if (moveTick) begin
            distLeft_q <= distLeft_q - 1'b1;
            timeout_q <= TO_W'(DOG_TIMEOUT);
          end else if (timeout_q == '0) begin
            state_q <= HS_ABORT;
          end else begin
            timeout_q <= timeout_q - 1'b1;
          end
        end
        default: begin
          state_q <= HS_IDLE;
        end
      endcase
    end
  end

  // Motion command outputs; edge error scales with this speed
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      speedCmd <= SPD_RESET;
      speedDir <= 1'b0;
      rampTime <= SPD_RESET;
      homingBusy <= 1'b0;
      homingAbort <= 1'b0;
    end else begin
      speedDir <= homing_direction_cfg_q;
      rampTime <= point1Accel_q;
      homingBusy <= (state_q == HS_FAST) || (state_q == HS_CREEP) ||
                    (state_q == HS_COUNT);
      homingAbort <= (state_q == HS_ABORT);
      case (state_q)
        HS_FAST: speedCmd <= homing_speed_cfg_q;
        HS_CREEP, HS_COUNT: speedCmd <= creep_speed_cfg_q;
        default: speedCmd <= SPD_RESET;
      endcase
    end
  end

  // Completion flag only after home data captured
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      homing_complete_flag <= 1'b0;
    end else if (state_q == HS_DONE) begin
      homing_complete_flag <= 1'b1;
    end else begin
      homing_complete_flag <= 1'b0;
    end
  end

  // Position counter: loaded at home, then follows travel pulses
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      position_q <= POS_RESET;
    end else if (state_q == HS_COUNT && distLeft_q == POS_RESET) begin
      position_q <= home_position_data_cfg_q;
    end else if (moveTick) begin
      if (homing_direction_cfg_q) begin
        position_q <= position_q - 1'b1;
      end else begin
        position_q <= position_q + 1'b1;
      end
    end
  end

  assign evDone = (state_q == HS_COUNT) && (distLeft_q == POS_RESET);
  // First cycle in abort, timeout or bad method alike
  assign evAbort = (state_q == HS_ABORT) && !homingAbort;
  assign evDog = (state_q == HS_FAST) && dogActive && !dogPrev_q;

  // Sticky flags; a new event wins over a write-one clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irqStat_q <= IRQ_RESET;
    end else begin
      irqStat_q <= (irqStat_q &
                    ~((regWr && regAddr == ADDR_IRQ_STAT) ? regWdata[2:0]
                                                         : 3'h0)) |
                   {evDog, evAbort, evDone};
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat_q & irqMask_q);
    end
  end

  // Register writes
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      homing_method_cfg_q <= 4'h0;
      homing_direction_cfg_q <= 1'b0;
      dog_polarity_cfg_q <= 1'b0;
      homing_speed_cfg_q <= SPD_RESET;
      creep_speed_cfg_q <= SPD_RESET;
      home_shift_distance_cfg_q <= POS_RESET;
      home_position_data_cfg_q <= POS_RESET;
      after_dog_distance_cfg_q <= POS_RESET;
      point1Accel_q <= SPD_RESET;
      irqMask_q <= IRQ_RESET;
    end else if (regWr) begin
      case (regAddr)
        ADDR_CTRL: begin
          homing_method_cfg_q <= regWdata[3:0];
          homing_direction_cfg_q <= regWdata[4];
          dog_polarity_cfg_q <= regWdata[5];
        end
        4'h5: homing_speed_cfg_q <= regWdata[SPD_W-1:0];
        4'h6: creep_speed_cfg_q <= regWdata[SPD_W-1:0];
        4'h7: home_shift_distance_cfg_q <= regWdata;
        4'h8: home_position_data_cfg_q <= regWdata;
        4'h9: after_dog_distance_cfg_q <= regWdata;
        4'hA: point1Accel_q <= regWdata[SPD_W-1:0];
        ADDR_IRQ_MASK: irqMask_q <= regWdata[2:0];
        default: begin
        end
      endcase
    end
  end

  // Read data one cycle after strobe, zero otherwise
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      regRdata <= 32'h00000000;
    end else if (regRd) begin
      case (regAddr)
        ADDR_CTRL: regRdata <= {26'h0, dog_polarity_cfg_q,
                                homing_direction_cfg_q, homing_method_cfg_q};
        ADDR_STATUS: regRdata <= {25'h0, dogSeen_q, homingAbort,
                                  homing_complete_flag, state_q, homingBusy};
        ADDR_IRQ_STAT: regRdata <= {29'h0, irqStat_q};
        ADDR_IRQ_MASK: regRdata <= {29'h0, irqMask_q};
        ADDR_POSITION: regRdata <= position_q;
        4'h5: regRdata <= {16'h0, homing_speed_cfg_q};
        4'h6: regRdata <= {16'h0, creep_speed_cfg_q};
        4'h7: regRdata <= home_shift_distance_cfg_q;
        4'h8: regRdata <= home_position_data_cfg_q;
        4'h9: regRdata <= after_dog_distance_cfg_q;
        4'hA: regRdata <= {16'h0, point1Accel_q};
        default: regRdata <= 32'h00000000;
      endcase
    end else begin
      regRdata <= 32'h00000000;
    end
  end
endmodule // dog_based_homing_sequencer
`default_nettype wire

// *** logic/homing_pkg.sv ***
// Constants, codes and reset values for the dog-based homing sequencer.
// Assumes one 40 MHz clock and a synchronous active-high reset.
package homing_pkg;
  localparam int POS_W = 32;
  localparam int SPD_W = 16;
  localparam logic [3:0] METHOD_REAR = 4'h5;
  localparam logic [3:0] METHOD_FRONT = 4'h6;
  localparam logic [3:0] METHOD_CRADLE = 4'h7;
  localparam logic [POS_W-1:0] POS_RESET = 32'h00000000;
  localparam logic [SPD_W-1:0] SPD_RESET = 16'h0000;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ABORT = 1;
  localparam int IRQ_DOG = 2;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
  localparam logic [3:0] ADDR_POSITION = 4'h4;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned DOG_TIMEOUT_MS = 1000;
  localparam int unsigned DOG_TIMEOUT_CYC = CLK_HZ / 1000 * DOG_TIMEOUT_MS;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_FAST = 3'b001,
    HS_CREEP = 3'b011,
    HS_COUNT = 3'b010,
    HS_DONE = 3'b110,
    HS_ABORT = 3'b111
  } home_state_type;
endpackage

// *** logic/pin_sync.sv ***
// Two-flop synchroniser for a bank of asynchronous pins.
// Assumes the inputs are levels slower than the clock.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_q <= '0;
      syncOut <= '0;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule // pin_sync
`default_nettype wire

// *** verif/homing_sva.sv ***
// Port assertions for the dog-based homing sequencer.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module homing_sva
  import homing_pkg::*;
#(
  parameter int unsigned DOG_TIMEOUT = 50
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic dogPin,
  input wire logic posPulse,
  input wire logic auto_manual_select,
  input wire logic [7:0] pointSel,
  input wire logic pos_speed_source_select,
  input wire logic twoStations,
  input wire logic homeStart,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic [SPD_W-1:0] speedCmd,
  input wire logic speedDir,
  input wire logic homing_complete_flag,
  input wire logic homingBusy,
  input wire logic homingAbort
);
  logic dogLast_q;
  logic pulseLast_q;
  logic [3:0] dogAge_q;
  logic [3:0] pulseAge_q;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // Ages since the last pin event; both saturate
  always_ff @(posedge mclk) begin
    dogLast_q <= dogPin;
    if (sys_rst || dogPin != dogLast_q) begin
      dogAge_q <= 4'h0;
    end else if (dogAge_q != 4'hF) begin
      dogAge_q <= dogAge_q + 4'h1;
    end
  end
  always_ff @(posedge mclk) begin
    pulseLast_q <= posPulse;
    if (sys_rst || (posPulse && !pulseLast_q)) begin
      pulseAge_q <= 4'h0;
    end else if (pulseAge_q != 4'hF) begin
      pulseAge_q <= pulseAge_q + 4'h1;
    end
  end
  property p_creep;
    $changed(speedCmd) && $past(speedCmd) != '0 && speedCmd != '0
      |-> dogAge_q inside {[4'h1:4'hA]};
  endproperty
  property p_done;
    $rose(homing_complete_flag) |-> pulseAge_q inside {[4'h1:4'hA]};
  endproperty
  property p_start;
    homeStart && !homingBusy && auto_manual_select && pointSel == 8'h00
      && (!twoStations || pos_speed_source_select)
      |-> ##[1:3] (homingBusy || homingAbort);
  endproperty
  property p_refuse;
    homeStart && !homingBusy && (!auto_manual_select || pointSel != 8'h00
      || (twoStations && !pos_speed_source_select)) |=> !homingBusy [*3];
  endproperty
  property p_hold;
    homing_complete_flag && !homeStart && !$past(homeStart)
      |=> homing_complete_flag;
  endproperty
  property p_abort;
    homingAbort |-> !homing_complete_flag && speedCmd == '0 && !homingBusy;
  endproperty
  property p_rd;
    !regRd |=> regRdata == 32'h00000000;
  endproperty
  property p_dir;
    homingBusy && $past(homingBusy) |-> $stable(speedDir);
  endproperty
  a_creep: assert property (p_creep)
    else $error("speed changed away from a dog edge");
  a_done: assert property (p_done)
    else $error("completion not tied to a travel pulse");
  a_start: assert property (p_start)
    else $error("valid start not taken");
  a_refuse: assert property (p_refuse)
    else $error("start taken outside manual mode");
  a_hold: assert property (p_hold)
    else $error("complete flag dropped without start");
  a_abort: assert property (p_abort)
    else $error("abort with flag or motion");
  a_rd: assert property (p_rd)
    else $error("read data outside its cycle");
  a_dir: assert property (p_dir)
    else $error("direction changed mid run");
  c_done: cover property ($rose(homing_complete_flag));
  c_abort: cover property ($rose(homingAbort));
  c_creep: cover property ($changed(speedCmd) && homingBusy);
endmodule // homing_sva
bind dog_based_homing_sequencer homing_sva #(.DOG_TIMEOUT(DOG_TIMEOUT)) sva (
  .mclk, .sys_rst, .dogPin, .posPulse, .auto_manual_select, .pointSel,
  .pos_speed_source_select, .twoStations, .homeStart, .regRd, .regRdata,
  .speedCmd, .speedDir, .homing_complete_flag, .homingBusy, .homingAbort
);
`default_nettype wire

// *** verif/axis_model.sv ***
// Far-side axis: travel pulses, proximity dog and Z index.
// Assumes one travel unit per eight clocks while speed is commanded.
`timescale 1ns/10ps
`default_nettype none
module axis_model
  import homing_pkg::*;
(
  input wire logic mclk,
  input wire logic homeStart,
  input wire logic [SPD_W-1:0] speedCmd,
  input wire logic dogPol,
  input wire logic dogEn,
  output logic dogPin,
  output logic zPhasePin,
  output logic posPulse,
  output logic [7:0] trav
);
  // Slow enough that the speed drop at home lands before the next unit
  logic [2:0] phase_q = 3'h0;
  initial begin
    posPulse = 1'b0;
    trav = 8'h00;
    dogPin = 1'b0;
    zPhasePin = 1'b0;
  end
  always @(posedge mclk) begin
    if (homeStart) begin
      phase_q <= 3'h0;
      posPulse <= 1'b0;
      trav <= 8'h00;
    end else if (speedCmd != '0) begin
      phase_q <= phase_q + 3'h1;
      if (phase_q == 3'h1) begin
        posPulse <= 1'b1;
        trav <= trav + 8'h01;
      end
      if (phase_q == 3'h5) begin
        posPulse <= 1'b0;
      end
    end
  end
  // Dog lags the step by a cycle, so no count straddles it
  always @(posedge mclk) begin
    dogPin <= dogPol ^ (dogEn && trav >= 8'h0A && trav < 8'h14);
    zPhasePin <= trav[2:0] == 3'h4;
  end
endmodule // axis_model
`default_nettype wire

// *** verif/dog_based_homing_sequencer_bench.sv ***
// Self-checking bench for the dog-based homing sequencer.
// Assumes axis_model on the far side and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module dog_based_homing_sequencer_bench;
  import homing_pkg::*;
  typedef struct {
    logic [3:0] mth;
    logic dir;
    logic pol;
    logic [31:0] aft;
    logic [31:0] sft;
    logic [7:0] trv;
  } row_type;
  localparam logic [15:0] HSPD = 16'h0123;
  localparam logic [15:0] CSPD = 16'h0020;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic homeStart = 1'b0;
  logic auto_manual_select = 1'b1;
  logic pos_speed_source_select = 1'b1;
  logic twoStations = 1'b1;
  logic [7:0] pointSel = 8'h00;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h00000000;
  logic dogPol = 1'b0;
  logic dogEn = 1'b1;
  logic dogPin, zPhasePin, posPulse, speedDir, irq;
  logic homing_complete_flag, homingBusy, homingAbort;
  logic [31:0] regRdata;
  logic [SPD_W-1:0] speedCmd, rampTime;
  logic [7:0] trav;
  int miscompares = 0;
  int totalChecks = 0;
  // Travel at completion: dog release (rear) or dog edge (front) plus after-dog and shift; Z edge plus shift (cradle)
  row_type rows [3] = '{
    '{4'h5, 1'b0, 1'b0, 32'h3, 32'h2, 8'h19},
    '{4'h6, 1'b1, 1'b1, 32'h4, 32'h1, 8'h0F},
    '{4'h7, 1'b0, 1'b0, 32'h5, 32'h3, 8'h0F}
  };
  always #12.5 mclk = ~mclk;
  dog_based_homing_sequencer #(.DOG_TIMEOUT(200)) dut (
    .mclk, .sys_rst, .dogPin, .zPhasePin, .posPulse, .auto_manual_select,
    .pointSel, .pos_speed_source_select, .twoStations, .homeStart,
    .regAddr, .regWdata, .regWr, .regRd, .regRdata, .speedCmd, .speedDir,
    .rampTime, .homing_complete_flag, .homingBusy, .homingAbort, .irq
  );
  axis_model far (.mclk, .homeStart, .speedCmd, .dogPol, .dogEn, .dogPin,
    .zPhasePin, .posPulse, .trav);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkB(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    chk(regRdata, exp);
  endtask
  // Speed command is due two cycles after the start edge
  task automatic start();
    @(posedge mclk);
    homeStart <= 1'b1;
    @(posedge mclk);
    homeStart <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic waitEnd();
    for (int i = 0; i < 2000; i++) begin
      @(posedge mclk);
      if (homing_complete_flag === 1'b1 || homingAbort === 1'b1) break;
    end
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(4'h3, 32'h0);
    wr(4'h5, {16'h0, HSPD});
    wr(4'h6, {16'h0, CSPD});
    wr(4'hA, 32'h55);
    wr(4'h3, 32'h1);
    rd(4'hF, 32'h0);
    chk({16'h0, rampTime}, 32'h55);
    foreach (rows[i]) begin
      @(posedge mclk);
      dogPol <= rows[i].pol;
      wr(4'h0, {26'h0, rows[i].pol, rows[i].dir, rows[i].mth});
      wr(4'h9, rows[i].aft);
      wr(4'h7, rows[i].sft);
      wr(4'h8, 32'hA5A50000 + 32'(i));
      start();
      chk({16'h0, speedCmd}, {16'h0, HSPD});
      chkB(speedDir, rows[i].dir);
      for (int j = 0; j < 400 && speedCmd === HSPD; j++) @(posedge mclk);
      #1;
      chk({16'h0, speedCmd}, {16'h0, CSPD});
      waitEnd();
      chkB(homing_complete_flag, 1'b1);
      chk({24'h0, trav}, {24'h0, rows[i].trv});
      rd(4'h4, 32'hA5A50000 + 32'(i));
      chkB(irq, 1'b1);
      wr(4'h2, 32'h7);
    end
    rd(4'h2, 32'h0);
    chkB(irq, 1'b0);
    // Refused starts leave the finished run standing
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk);
      auto_manual_select <= (k != 0);
      pointSel <= (k == 1) ? 8'h10 : 8'h00;
      pos_speed_source_select <= (k != 2);
      start();
      chkB(homingBusy, 1'b0);
      chkB(homing_complete_flag, 1'b1);
    end
    @(posedge mclk);
    auto_manual_select <= 1'b1;
    pos_speed_source_select <= 1'b1;
    wr(4'h3, 32'h2);
    wr(4'h0, 32'h0);
    start();
    waitEnd();
    chk({30'h0, homingAbort, homing_complete_flag}, 32'h2);
    rd(4'h2, 32'h2);
    chkB(irq, 1'b1);
    wr(4'h2, 32'h7);
    dogEn <= 1'b0;
    wr(4'h0, 32'h5);
    start();
    waitEnd();
    chk({30'h0, homingAbort, homing_complete_flag}, 32'h2);
    wr(4'h3, 32'h0);
    rd(4'h2, 32'h2);
    chkB(irq, 1'b0);
    @(posedge mclk);
    dogEn <= 1'b1;
    start();
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    chk({13'h0, homingBusy, homingAbort, homing_complete_flag, speedCmd}, 0);
    rd(4'h5, {16'h0, SPD_RESET});
    wrap_up();
  end
endmodule // dog_based_homing_sequencer_bench
`default_nettype wire
